// ==== verilog/pixel_compare_defines.svh ====
`ifndef PIXEL_COMPARE_DEFINES_SVH
`define PIXEL_COMPARE_DEFINES_SVH

// Result pixel values
`define RESULT_TRUE  8'hFF
`define RESULT_FALSE 8'h00
// Relation-select encodings
`define REL_EQUAL         3'h0
`define REL_GREATER       3'h1
`define REL_GREATER_EQUAL 3'h2
`define REL_LESS          3'h3
`define REL_LESS_EQUAL    3'h4
`define REL_NOT_EQUAL     3'h5
// Default image size
`define DEFAULT_ROWS 16'h01E0
`define DEFAULT_COLS 16'h0280

`endif

// ==== verilog/pixel_compare_pkg.sv ====
package pixel_compare_pkg;
	typedef enum logic [2:0] {
		rel_equal,
		rel_greater,
		rel_greater_equal,
		rel_less,
		rel_less_equal,
		rel_not_equal
	} relation_type;

	typedef enum logic [0:0] {
		st_idle,
		st_run
	} phase_type;
endpackage : pixel_compare_pkg

// ==== verilog/relation_unit.sv ====
`include "pixel_compare_defines.svh"

// Combinational relation of one channel; first operand is the left-hand side
module relation_unit #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] left_value,
	input  wire logic [WIDTH-1:0] right_value,
	input  wire logic [2:0]       relation,
	output logic                  holds
);
	// Unknown codes answer false so a bad setting yields an all-zero image
	always_comb begin
		case (relation)
			`REL_EQUAL:         holds = (left_value == right_value);
			`REL_GREATER:       holds = (left_value >  right_value);
			`REL_GREATER_EQUAL: holds = (left_value >= right_value);
			`REL_LESS:          holds = (left_value <  right_value);
			`REL_LESS_EQUAL:    holds = (left_value <= right_value);
			`REL_NOT_EQUAL:     holds = (left_value != right_value);
			default:            holds = 1'b0;
		endcase
	end
endmodule // relation_unit

// ==== verilog/pixel_compare_engine.sv ====
`include "pixel_compare_defines.svh"

// Notes on behaviour
// - Two-image mode compares first and second image pixels at equal positions.
// - Result pixel is 255 when the relation holds, else 0.
// - Six relations selectable; first image pixel is the left operand.
// - Result image has one 8-bit value per source channel.
// - Scalar mode compares every pixel with one constant scalar.
// - Each source pixel is read once; a full result image is emitted.
// - Two-image result keeps the input rows, columns and channels.
// - Scalar-mode result keeps the source rows, columns and channels.

// Handshake summary
// Readies are registered and rise only while the result slot is empty.
// A beat is consumed on an edge where its valid and the shown ready are both high.
// Two-image mode consumes the first and second beats on the same edge.
// A result stands until the downstream ready is seen high.
// Registered readies cost throughput: one pixel every two cycles at best.
// One idle cycle between images latches the next image's settings.
// BUSY is low for that one cycle between images.
// Settings that change mid-image apply from the next image only.
// ROWS and COLS are fixed when built; there is no runtime image size.
// Unknown relation codes give an all-zero image rather than a stale relation.
// The result is one 8-bit value per source channel.
// Only SYS_CLK clocks this block; every input is taken as same-clock logic.
module pixel_compare_engine #(
	parameter int          CHANNELS   = 1,
	parameter int          PIXEL_BITS = 8,
	parameter logic [15:0] ROWS       = `DEFAULT_ROWS,
	parameter logic [15:0] COLS       = `DEFAULT_COLS
) (
	// Clock and synchronous reset
	input  wire logic                           SYS_CLK,
	input  wire logic                           NRST,
	// Image settings, taken at image start only
	input  wire logic                           SCALAR_MODE,
	input  wire logic [2:0]                     RELATION_SELECT,
	input  wire logic [CHANNELS*PIXEL_BITS-1:0] SCALAR_VALUE,
	// First source stream
	input  wire logic [CHANNELS*PIXEL_BITS-1:0] FIRST_IMAGE_IN_DATA,
	input  wire logic                           FIRST_IMAGE_IN_VALID,
	output logic                                FIRST_IMAGE_IN_READY,
	// Second source stream, left alone in scalar mode
	input  wire logic [CHANNELS*PIXEL_BITS-1:0] SECOND_IMAGE_IN_DATA,
	input  wire logic                           SECOND_IMAGE_IN_VALID,
	output logic                                SECOND_IMAGE_IN_READY,
	// Result stream
	output logic [CHANNELS*8-1:0]               RESULT_DATA,
	output logic                                RESULT_VALID,
	input  wire logic                           RESULT_READY,
	output logic                                RESULT_LAST,
	// Image in progress
	output logic                                BUSY
);
	// Result pixels are 8 bits per channel whatever the source depth
	localparam int RESULT_BITS = 8;
	// Raster end points, fixed when built
	localparam logic [15:0] LAST_COL = COLS - 16'h0001;
	localparam logic [15:0] LAST_ROW = ROWS - 16'h0001;

	// All state lives in one register; next_state is its combinational copy
	typedef struct packed {
		// Sequencing and the settings latched at image start
		pixel_compare_pkg::phase_type    phase;
		logic [2:0]                      relation;
		logic                            scalar_mode;
		logic [CHANNELS*PIXEL_BITS-1:0]  scalar;
		// Raster position of the next input pixel
		logic [15:0]                     row;
		logic [15:0]                     col;
		// Registered input readies
		logic                            in_ready_first;
		logic                            in_ready_second;
		// Result slot and status
		logic [CHANNELS*8-1:0]           result;
		logic                            result_valid;
		logic                            result_last;
		logic                            busy;
	} state_type;

	state_type state;
	state_type next_state;

	// Combinational helpers feeding the next-state logic
	logic [CHANNELS-1:0]             holds;
	logic [CHANNELS*PIXEL_BITS-1:0]  right_operand;
	logic [CHANNELS*RESULT_BITS-1:0] result_word;
	logic                            in_run;
	logic                            input_pair_valid;
	logic                            drain;
	logic                            slot_free;
	logic                            take;
	logic                            col_at_end;
	logic                            row_at_end;
	logic                            image_end;

	// Second operand is the other image or the latched scalar
	assign right_operand = state.scalar_mode ? state.scalar : SECOND_IMAGE_IN_DATA;

	// Per-channel comparators; the result keeps the source channel count
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
			// Left operand is always the first image pixel
			relation_unit #(
				.WIDTH (PIXEL_BITS)
			) u_relation (
				.left_value  (FIRST_IMAGE_IN_DATA[ch*PIXEL_BITS +: PIXEL_BITS]),
				.right_value (right_operand[ch*PIXEL_BITS +: PIXEL_BITS]),
				.relation    (state.relation),
				.holds       (holds[ch])
			);
			// A true relation gives a full-scale byte, a false one zero
			assign result_word[ch*RESULT_BITS +: RESULT_BITS] = holds[ch] ? `RESULT_TRUE
				: `RESULT_FALSE;
		end
	endgenerate

	// Phase decode shared by the handshake terms
	assign in_run = (state.phase == pixel_compare_pkg::st_run);

	// One pixel per transfer; both streams must be present together in two-image mode
	assign input_pair_valid = FIRST_IMAGE_IN_VALID
		& (state.scalar_mode | SECOND_IMAGE_IN_VALID);
	// Downstream takes the standing result on this edge
	assign drain     = state.result_valid & RESULT_READY;
	assign slot_free = ~state.result_valid | RESULT_READY;
	// A beat counts only where the registered ready was shown, so none is lost upstream
	assign take = in_run & state.in_ready_first & input_pair_valid & slot_free;

	// Raster position decode; the last column of the last row ends the image
	assign col_at_end = (state.col == LAST_COL);
	assign row_at_end = (state.row == LAST_ROW);
	assign image_end  = col_at_end & row_at_end;

	// Next-state logic
	always_comb begin
		next_state = state;
		// Output slot drains independently of new inputs
		if (drain) begin
			next_state.result_valid = 1'b0;
			next_state.result_last  = 1'b0;
		end

		// Idle lasts one cycle and only prepares the next image
		case (state.phase)
			pixel_compare_pkg::st_idle: begin
				// Latch settings at image start so mid-image changes cannot tear it
				next_state.relation    = RELATION_SELECT;
				next_state.scalar_mode = SCALAR_MODE;
				// Scalar is captured in both modes; two-image mode ignores it
				next_state.scalar      = SCALAR_VALUE;
				// Every image starts at the top-left pixel
				next_state.row         = 16'h0000;
				next_state.col         = 16'h0000;
				// Readies can rise on the same edge that enters this run phase
				next_state.phase       = pixel_compare_pkg::st_run;
				next_state.busy        = 1'b1;
			end

			pixel_compare_pkg::st_run: begin
				// Without a take the result data and the position keep their values
				if (take) begin
					// A taken beat always lands in an empty slot
					next_state.result       = result_word;
					next_state.result_valid = 1'b1;
					next_state.result_last  = image_end;
					// Raster walk bounds the image to ROWS x COLS
					if (col_at_end) begin
						next_state.col = 16'h0000;
						if (row_at_end) begin
							// The final pixel closes the image; BUSY falls with it
							next_state.phase = pixel_compare_pkg::st_idle;
							next_state.busy  = 1'b0;
						end else begin
							next_state.row = state.row + 16'h0001;
						end
					end else begin
						next_state.col = state.col + 16'h0001;
					end
				end
			end
			default: begin
				// An illegal phase recovers through idle
				next_state.phase = pixel_compare_pkg::st_idle;
			end
		endcase

		// Readies are registered, so they look one cycle ahead at the slot
		// A slot still full next cycle holds both readies low: that is the stall
		// In idle both readies stay low, so no beat is taken between images
		next_state.in_ready_first  = (next_state.phase == pixel_compare_pkg::st_run)
			& ~next_state.result_valid;
		// The second stream is never offered a beat in scalar mode
		next_state.in_ready_second = next_state.in_ready_first & ~next_state.scalar_mode;
	end

	// State register; reset empties the result slot and drops every ready
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Registered readies
	assign FIRST_IMAGE_IN_READY  = state.in_ready_first;
	assign SECOND_IMAGE_IN_READY = state.in_ready_second;
	// Result stream; data, valid and last leave the same register together
	assign RESULT_DATA           = state.result;
	assign RESULT_VALID          = state.result_valid;
	assign RESULT_LAST           = state.result_last;
	// Image in progress
	assign BUSY                  = state.busy;
endmodule // pixel_compare_engine

// ==== testbench/pixel_compare_engine_assertions.sv ====
module pixel_compare_checker #(
	parameter logic [15:0] ROWS = 16'h0002,
	parameter logic [15:0] COLS = 16'h0003
) (
	input wire logic       SYS_CLK,
	input wire logic       NRST,
	input wire logic       SCALAR_MODE,
	input wire logic       FIRST_IMAGE_IN_VALID,
	input wire logic       FIRST_IMAGE_IN_READY,
	input wire logic       SECOND_IMAGE_IN_READY,
	input wire logic [7:0] RESULT_DATA,
	input wire logic       RESULT_VALID,
	input wire logic       RESULT_READY,
	input wire logic       RESULT_LAST
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] cnt;
	// Results taken so far in this image; cleared on reset so a mid-image reset starts fresh
	always_ff @(posedge SYS_CLK) begin
		if (!NRST || (RESULT_VALID && RESULT_READY && RESULT_LAST)) cnt <= 32'h0;
		else if (RESULT_VALID && RESULT_READY) cnt <= cnt + 32'h1;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	sequence s_take; FIRST_IMAGE_IN_VALID && FIRST_IMAGE_IN_READY; endsequence
	sequence s_out; RESULT_VALID && RESULT_READY; endsequence
	property p_answer; s_take |=> RESULT_VALID; endproperty
	property p_hold; RESULT_VALID && !RESULT_READY |=> RESULT_VALID && $stable(RESULT_DATA);
	endproperty
	property p_values; RESULT_VALID |-> RESULT_DATA inside {8'h00, 8'hFF}; endproperty
	property p_pair; FIRST_IMAGE_IN_READY && !SCALAR_MODE |-> SECOND_IMAGE_IN_READY; endproperty
	property p_scalar; FIRST_IMAGE_IN_READY && SCALAR_MODE |-> !SECOND_IMAGE_IN_READY; endproperty
	property p_last; RESULT_VALID |-> RESULT_LAST == (cnt + 32'h1 == ROWS * COLS); endproperty
	property p_stall; RESULT_VALID && !RESULT_READY |-> !FIRST_IMAGE_IN_READY; endproperty
	property p_drain; s_out |=> !RESULT_VALID; endproperty
	a_answer: assert property (p_answer) else $error("no result");
	a_hold: assert property (p_hold) else $error("result dropped");
	a_values: assert property (p_values) else $error("bad value");
	a_pair: assert property (p_pair) else $error("unpaired");
	a_scalar: assert property (p_scalar) else $error("second taken");
	a_last: assert property (p_last) else $error("bad last");
	a_stall: assert property (p_stall) else $error("no stall");
	a_drain: assert property (p_drain) else $error("stale result");
endmodule // pixel_compare_checker

// ==== testbench/result_sink.sv ====
module result_sink (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic stall,
	output logic      ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// Empty after reset; stalling toggles ready so results must wait and hold
	always_ff @(posedge clk) begin
		if (!nrst) ready <= 1'b0;
		else ready <= stall ? ~ready : 1'b1;
	end
endmodule // result_sink

// ==== testbench/tb_pixel_compare_engine.sv ====
module tb_pixel_compare_engine;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 1'b0, nrst = 1'b0, smode = 1'b0, v1 = 1'b0, v2 = 1'b0, stall = 1'b0;
	logic [2:0] rel = 3'h0;
	logic [7:0] sv = 8'h00, d1 = 8'h00, d2 = 8'h00, rdata;
	logic       r1, r2, rvalid, rready, rlast, busy;
	int         n_fail = 0, total_checks = 0, cyc = 0;
	logic [7:0] a [6] = '{8'h00, 8'h7F, 8'hFF, 8'h80, 8'h01, 8'h10};
	logic [7:0] b [6] = '{8'h00, 8'h80, 8'hFE, 8'h80, 8'h02, 8'h10};
	always #20 clk = ~clk;
	pixel_compare_engine #(.ROWS(16'h0002), .COLS(16'h0003)) dut (.SYS_CLK(clk), .NRST(nrst),
		.SCALAR_MODE(smode), .RELATION_SELECT(rel), .SCALAR_VALUE(sv),
		.FIRST_IMAGE_IN_DATA(d1), .FIRST_IMAGE_IN_VALID(v1), .FIRST_IMAGE_IN_READY(r1),
		.SECOND_IMAGE_IN_DATA(d2), .SECOND_IMAGE_IN_VALID(v2), .SECOND_IMAGE_IN_READY(r2),
		.RESULT_DATA(rdata), .RESULT_VALID(rvalid), .RESULT_READY(rready),
		.RESULT_LAST(rlast), .BUSY(busy));
	result_sink sink (.clk(clk), .nrst(nrst), .stall(stall), .ready(rready));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function logic holds(input logic [7:0] x, input logic [7:0] y, input logic [2:0] r);
		return (r == 3'h0 && x == y) || (r == 3'h1 && x > y) || (r == 3'h2 && x >= y)
			|| (r == 3'h3 && x < y) || (r == 3'h4 && x <= y) || (r == 3'h5 && x != y);
	endfunction
	task final_report;
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Settings go in under reset, since they are only taken at image start
	task run_image(input logic s, input logic [2:0] r, input logic st);
		@(posedge clk);
		nrst <= 1'b0; smode <= s; rel <= r; stall <= st; sv <= 8'h80;
		@(posedge clk);
		nrst <= 1'b1;
		fork
			begin
				// Valid stays up across beats; data moves only on a handshake edge
				for (int i = 0; i < 6; i++) begin
					v1 <= 1'b1; d1 <= a[i]; v2 <= !s; d2 <= b[i];
					if (i == 2) begin rel <= ~r; sv <= 8'h00; end
					do @(negedge clk); while (!r1);
					check({7'h00, r2}, {7'h00, !s});
					check({7'h00, busy}, 8'h01);
					@(posedge clk);
				end
				v1 <= 1'b0;
				v2 <= 1'b0;
			end
			for (int j = 0; j < 6; j++) begin
				do @(negedge clk); while (!(rvalid && rready));
				check(rdata, holds(a[j], s ? 8'h80 : b[j], r) ? 8'hFF : 8'h00);
				check({7'h00, rlast}, {7'h00, j == 5});
				if (j == 5 && !st) check({7'h00, busy}, 8'h00);
				@(posedge clk);
			end
		join
	endtask
	// Every relation between two images, equal and boundary pixels included
	task test_relations;
		for (int r = 0; r < 6; r++) run_image(1'b0, 3'(r), 1'b0);
	endtask
	// One constant against every pixel
	task test_scalar;
		run_image(1'b1, 3'h1, 1'b0);
		run_image(1'b1, 3'h4, 1'b0);
	endtask
	// Back-pressure, plus an unused relation code that must give all zero
	task test_stall;
		run_image(1'b0, 3'h5, 1'b1);
		run_image(1'b1, 3'h6, 1'b1);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		test_relations;
		test_scalar;
		test_stall;
		final_report;
	end
endmodule // tb_pixel_compare_engine
bind pixel_compare_engine pixel_compare_checker #(.ROWS(ROWS), .COLS(COLS)) chk (
	.SYS_CLK(SYS_CLK), .NRST(NRST), .SCALAR_MODE(SCALAR_MODE),
	.FIRST_IMAGE_IN_VALID(FIRST_IMAGE_IN_VALID), .FIRST_IMAGE_IN_READY(FIRST_IMAGE_IN_READY),
	.SECOND_IMAGE_IN_READY(SECOND_IMAGE_IN_READY), .RESULT_DATA(RESULT_DATA),
	.RESULT_VALID(RESULT_VALID), .RESULT_READY(RESULT_READY), .RESULT_LAST(RESULT_LAST));
